// ===== core/cpsw_regs.vh
`ifndef CPSW_REGS_VH
`define CPSW_REGS_VH

// Register byte addresses
`define CPSW_ADDR_STATUS 4'h0
`define CPSW_ADDR_MASK 4'h4
`define CPSW_ADDR_WORD 4'h8

// Serial control word
`define CPSW_WORD_BITS 11
`define CPSW_WORD_RESET 11'h000

// Control word field positions
`define CPSW_B_A_PROG_HI 0
`define CPSW_B_A_PROG_LO 1
`define CPSW_B_A_MAIN_LO 2
`define CPSW_B_A_MAIN_HI 3
`define CPSW_B_B_PROG_HI 4
`define CPSW_B_B_PROG_LO 5
`define CPSW_B_B_MAIN_HI 6
`define CPSW_B_B_MAIN_LO 7
`define CPSW_B_RUN 8
`define CPSW_B_A_PROG_LVL 9
`define CPSW_B_B_PROG_LVL 10

// Status and mask bit positions
`define CPSW_ST_LATCH 0
`define CPSW_ST_OC_LO 1
`define CPSW_ST_THERM 5
`define CPSW_ST_BITS 6
`define CPSW_ST_RESET 6'h00

// Word register read-back positions
`define CPSW_WR_VALID 16
`define CPSW_WR_SHUTDOWN_PIN_N 17
`define CPSW_WR_THERM 18

// Output encodings
`define CPSW_MAIN_0V 2'h0
`define CPSW_MAIN_3V3 2'h1
`define CPSW_MAIN_5V 2'h2
`define CPSW_PROG_0V 2'h0
`define CPSW_PROG_LOW 2'h1
`define CPSW_PROG_12V 2'h2

`endif

// ===== core/cpsw_sync.v
`timescale 1ns/1ns
// Two-flop synchroniser for a bundle of asynchronous levels
module cpsw_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	// Clocking
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// Levels
	input wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);

reg [W-1:0] meta_r; // First stage, read only by second stage
reg [W-1:0] sync_r; // Second stage

////////////////////////////////////////////////////////////////////////////////
// Two stages, reset to a safe constant
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		meta_r <= INIT;
		sync_r <= INIT;
	end else if (ce_i) begin
		meta_r <= async_i;
		sync_r <= meta_r;
	end
end

assign sync_o = sync_r;

endmodule // cpsw_sync

// ===== core/cpsw_slot_dec.v
`timescale 1ns/1ns
`include "cpsw_regs.vh"
// Switch selection of one card slot
module cpsw_slot_dec #(
	parameter HAS_12V = 1
) (
	// Slot fields of the active word
	input wire [1:0] main_code_i,
	input wire [1:0] prog_code_i,
	input wire prog_level_i,
	// Overrides
	input wire ground_i,
	input wire hiz_i,
	// Switch closures: main {dis,5v,3v3}, prog {dis,12v,5v,3v3}
	output reg [2:0] main_sw_nxt_o,
	output reg [3:0] prog_sw_nxt_o
);

////////////////////////////////////////////////////////////////////////////////
// Ground beats high impedance, which beats the coded selection
always @* begin
	main_sw_nxt_o = 3'h0;
	prog_sw_nxt_o = 4'h0;
	if (ground_i) begin
		// Only the discharge switches closed
		main_sw_nxt_o = 3'h4;
		prog_sw_nxt_o = 4'h8;
	end else if (!hiz_i) begin
		// Main supply, both 00 and 11 give 0 V
		case (main_code_i)
			`CPSW_MAIN_3V3: main_sw_nxt_o = 3'h1;
			`CPSW_MAIN_5V: main_sw_nxt_o = 3'h2;
			default: main_sw_nxt_o = 3'h4;
		endcase
		// Programming supply, 11 leaves it floating
		case (prog_code_i)
			`CPSW_PROG_0V: prog_sw_nxt_o = 4'h8;
			`CPSW_PROG_LOW: prog_sw_nxt_o = prog_level_i ? 4'h2 : 4'h1;
			`CPSW_PROG_12V: prog_sw_nxt_o = (HAS_12V != 0) ? 4'h4 : 4'h0;
			default: prog_sw_nxt_o = 4'h0;
		endcase
	end
end

endmodule // cpsw_slot_dec

// ===== core/cpsw_ctrl.v
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "cpsw_regs.vh"
// Overview of operation
// - Shift data on each serial clock rise
// - Latch rise loads last eleven bits
// - Pin or word bit forces all outputs floating unless grounded
// - Reset pin grounds all four outputs
// - Stay grounded until a word is latched
// - Latch edges ignored during reset
// - Flag low on overcurrent or overtemperature
// - Limit only the overloaded output
// - Overtemperature turns all off with hysteresis
// - Zero volt selection closes discharge switch
// - Programming supply from code and level
// - Main supply from two code bits
module cpsw_ctrl #(
	parameter HAS_12V = 1,
	parameter AW = 4
) (
	// Clocking
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// Serial link pins
	input wire ser_data_i,
	input wire ser_clock_i,
	input wire ser_latch_i,
	// Control pins
	input wire reset_pin_n_i,
	input wire shutdown_pin_n_i,
	// Analog sense: {b prog, b main, a prog, a main}
	input wire [3:0] oc_sense_i,
	input wire temp_hot_i,
	input wire temp_cool_i,
	// Register port
	input wire [AW-1:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output wire [31:0] reg_rdata_o,
	// Switch closures per slot
	output wire [2:0] slot_a_main_sw_o,
	output wire [3:0] slot_a_prog_sw_o,
	output wire [2:0] slot_b_main_sw_o,
	output wire [3:0] slot_b_prog_sw_o,
	// Protection outputs
	output wire [3:0] current_limit_o,
	output wire overcurrent_flag_n_o,
	output wire irq_o
);

////////////////////////////////////////////////////////////////////////////////
// Declarations

wire [4:0] pin_s; // Synchronised serial and control pins
wire [5:0] ana_s; // Synchronised analog sense levels
wire data_s; // Serial data, synchronised
wire sclk_s; // Serial clock, synchronised
wire latch_s; // Latch, synchronised
wire rstpin_n_s; // Device reset pin, synchronised
wire shutdown_pin_n_n_s; // Shutdown pin, synchronised
wire [3:0] oc_s; // Overcurrent sense, synchronised
wire hot_s; // Over-temperature trip
wire cool_s; // Below release threshold
reg sclk_d_r; // Serial clock one cycle back
reg latch_d_r; // Latch one cycle back
wire sclk_rise; // Serial clock rising edge
wire latch_rise; // Latch rising edge
wire latch_take; // Latch edge accepted
reg [10:0] shift_r; // Serial shift register
reg [10:0] word_r; // Active control word
reg valid_r; // A word has been latched since reset
reg therm_r; // Thermal shutdown in force
reg [3:0] oc_d_r; // Overcurrent sense one cycle back
reg therm_d_r; // Thermal state one cycle back
wire shutdown; // Shutdown from pin or word
wire ground; // Discharge state
wire hiz; // Floating state
wire [2:0] a_main_nxt; // Slot A main switches, next
wire [3:0] a_prog_nxt; // Slot A programming switches, next
wire [2:0] b_main_nxt; // Slot B main switches, next
wire [3:0] b_prog_nxt; // Slot B programming switches, next
reg [2:0] a_main_r; // Slot A main switches
reg [3:0] a_prog_r; // Slot A programming switches
reg [2:0] b_main_r; // Slot B main switches
reg [3:0] b_prog_r; // Slot B programming switches
wire [3:0] powered; // Outputs with a supply switch closed
reg [3:0] limit_r; // Current limit per output
reg oc_flag_n_r; // Overcurrent flag, active low
wire [5:0] events; // Event pulses into status
reg [5:0] status_r; // Sticky status
reg [5:0] mask_r; // Interrupt enables
reg irq_r; // Interrupt level
reg [31:0] rdata_r; // Read data
reg [31:0] rdata_nxt; // Read data, next

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; reset and shutdown pins start high so reset pin does not glitch low
cpsw_sync #(
	.W(5),
	.INIT(5'h18)
) u_pin_sync (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.ce_i(ce_i),
	.async_i({reset_pin_n_i, shutdown_pin_n_i, ser_latch_i, ser_clock_i, ser_data_i}),
	.sync_o(pin_s)
);

// Analog sense synchronisers
cpsw_sync #(
	.W(6),
	.INIT(6'h00)
) u_ana_sync (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.ce_i(ce_i),
	.async_i({temp_cool_i, temp_hot_i, oc_sense_i}),
	.sync_o(ana_s)
);

assign data_s = pin_s[0];
assign sclk_s = pin_s[1];
assign latch_s = pin_s[2];
assign shutdown_pin_n_n_s = pin_s[3];
assign rstpin_n_s = pin_s[4];
assign oc_s = ana_s[3:0];
assign hot_s = ana_s[4];
assign cool_s = ana_s[5];

////////////////////////////////////////////////////////////////////////////////
// Edge detection on the sampled link clock and latch
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		sclk_d_r <= 1'b0;
		latch_d_r <= 1'b0;
	end else if (ce_i) begin
		sclk_d_r <= sclk_s;
		latch_d_r <= latch_s;
	end
end

assign sclk_rise = sclk_s & ~sclk_d_r;
assign latch_rise = latch_s & ~latch_d_r;
// Latch edges while the reset pin is low are dropped
assign latch_take = latch_rise & rstpin_n_s;

////////////////////////////////////////////////////////////////////////////////
// Shift register, first bit shifted ends up as bit 0
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		shift_r <= `CPSW_WORD_RESET;
	end else if (ce_i && sclk_rise) begin
		// Data travels through the same two stages as the clock
		shift_r <= {data_s, shift_r[10:1]};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Active word and the grounded-until-latched state
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		word_r <= `CPSW_WORD_RESET;
		valid_r <= 1'b0;
	end else if (ce_i) begin
		if (!rstpin_n_s) begin
			// Reset pin drops back to the grounded state
			valid_r <= 1'b0;
		end else if (latch_take) begin
			// Only a latch edge changes the word
			word_r <= shift_r;
			valid_r <= 1'b1;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Thermal shutdown with hysteresis
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		therm_r <= 1'b0;
	end else if (ce_i) begin
		if (hot_s) begin
			therm_r <= 1'b1;
		end else if (cool_s) begin
			// Release only once below the lower threshold
			therm_r <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Output state selection
// Word bit low means shutdown, as does the shutdown pin
assign shutdown = ~shutdown_pin_n_n_s | ~word_r[`CPSW_B_RUN];
assign ground = ~rstpin_n_s | ~valid_r;
assign hiz = shutdown | therm_r;

// Slot A
cpsw_slot_dec #(
	.HAS_12V(HAS_12V)
) u_dec_a (
	.main_code_i({word_r[`CPSW_B_A_MAIN_HI], word_r[`CPSW_B_A_MAIN_LO]}),
	.prog_code_i({word_r[`CPSW_B_A_PROG_HI], word_r[`CPSW_B_A_PROG_LO]}),
	.prog_level_i(word_r[`CPSW_B_A_PROG_LVL]),
	.ground_i(ground),
	.hiz_i(hiz),
	.main_sw_nxt_o(a_main_nxt),
	.prog_sw_nxt_o(a_prog_nxt)
);

// Slot B
cpsw_slot_dec #(
	.HAS_12V(HAS_12V)
) u_dec_b (
	.main_code_i({word_r[`CPSW_B_B_MAIN_HI], word_r[`CPSW_B_B_MAIN_LO]}),
	.prog_code_i({word_r[`CPSW_B_B_PROG_HI], word_r[`CPSW_B_B_PROG_LO]}),
	.prog_level_i(word_r[`CPSW_B_B_PROG_LVL]),
	.ground_i(ground),
	.hiz_i(hiz),
	.main_sw_nxt_o(b_main_nxt),
	.prog_sw_nxt_o(b_prog_nxt)
);

////////////////////////////////////////////////////////////////////////////////
// Switch registers, grounded from reset
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		a_main_r <= 3'h4;
		a_prog_r <= 4'h8;
		b_main_r <= 3'h4;
		b_prog_r <= 4'h8;
	end else if (ce_i) begin
		a_main_r <= a_main_nxt;
		a_prog_r <= a_prog_nxt;
		b_main_r <= b_main_nxt;
		b_prog_r <= b_prog_nxt;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Per-output current limit and shared overcurrent flag
assign powered = {|b_prog_r[2:0], |b_main_r[1:0], |a_prog_r[2:0], |a_main_r[1:0]};

always @(posedge clk_i) begin
	if (!rst_n_i) begin
		limit_r <= 4'h0;
		oc_flag_n_r <= 1'b1;
	end else if (ce_i) begin
		// Each output limited on its own sense only
		limit_r <= oc_s & powered;
		// Raw trip joins the thermal state so a hand-over from overcurrent cannot blip high
		oc_flag_n_r <= ~(|oc_s | hot_s | therm_r);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Events: latch taken, overcurrent onset per output, thermal trip
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		oc_d_r <= 4'h0;
		therm_d_r <= 1'b0;
	end else if (ce_i) begin
		oc_d_r <= oc_s;
		therm_d_r <= therm_r;
	end
end

assign events = {therm_r & ~therm_d_r, oc_s & ~oc_d_r, latch_take};

////////////////////////////////////////////////////////////////////////////////
// Status, mask and interrupt
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		status_r <= `CPSW_ST_RESET;
		mask_r <= `CPSW_ST_RESET;
		irq_r <= 1'b0;
	end else if (ce_i) begin
		// Read clears, a new event in the same cycle survives
		if (reg_rd_i && reg_addr_i == `CPSW_ADDR_STATUS) begin
			status_r <= events;
		end else begin
			status_r <= status_r | events;
		end
		if (reg_wr_i && reg_addr_i == `CPSW_ADDR_MASK) begin
			mask_r <= reg_wdata_i[5:0];
		end
		irq_r <= |(status_r & mask_r);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read decode; unmapped addresses read zero
always @* begin
	rdata_nxt = 32'h0000_0000;
	case (reg_addr_i)
		`CPSW_ADDR_STATUS: begin
			rdata_nxt[5:0] = status_r;
		end
		`CPSW_ADDR_MASK: begin
			rdata_nxt[5:0] = mask_r;
		end
		`CPSW_ADDR_WORD: begin
			rdata_nxt[10:0] = word_r;
			rdata_nxt[`CPSW_WR_VALID] = valid_r;
			rdata_nxt[`CPSW_WR_SHUTDOWN_PIN_N] = shutdown;
			rdata_nxt[`CPSW_WR_THERM] = therm_r;
		end
		default: begin
			rdata_nxt = 32'h0000_0000;
		end
	endcase
end

// Read data valid only in the cycle after the strobe
always @(posedge clk_i) begin
	if (!rst_n_i) begin
		rdata_r <= 32'h0000_0000;
	end else if (ce_i) begin
		rdata_r <= reg_rd_i ? rdata_nxt : 32'h0000_0000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs
assign reg_rdata_o = rdata_r;
assign slot_a_main_sw_o = a_main_r;
assign slot_a_prog_sw_o = a_prog_r;
assign slot_b_main_sw_o = b_main_r;
assign slot_b_prog_sw_o = b_prog_r;
assign current_limit_o = limit_r;
assign overcurrent_flag_n_o = oc_flag_n_r;
assign irq_o = irq_r;

endmodule // cpsw_ctrl

// ===== verif/cpsw_ser_host.sv
`timescale 1ns/1ns
// Host side of the three-wire serial link
module cpsw_ser_host (
	// Clocking
	input wire clk_i,
	// Serial link pins
	output reg ser_data_o,
	output reg ser_clock_o,
	output reg ser_latch_o
);
	localparam HALF = 8; // Half link period, 32 ns at 4 ns
	integer k;
	initial begin
		ser_data_o = 1'b0;
		ser_clock_o = 1'b0;
		ser_latch_o = 1'b0;
	end
	// Shift n bits, bit 0 first, then latch if asked
	task send(input [15:0] bits, input integer n, input reg do_latch);
		begin
			for (k = 0; k < n; k = k + 1) begin
				ser_data_o <= bits[k]; // Valid a half period before the rise
				repeat (HALF) @(posedge clk_i);
				ser_clock_o <= 1'b1;
				repeat (HALF) @(posedge clk_i);
				ser_clock_o <= 1'b0;
			end
			// Released data line shows the inverse of the last bit
			ser_data_o <= ~bits[n-1];
			repeat (4) @(posedge clk_i);
			if (do_latch) begin
				ser_latch_o <= 1'b1; // Rise before any further clock rise
				repeat (HALF) @(posedge clk_i);
				ser_latch_o <= 1'b0;
			end
			repeat (HALF) @(posedge clk_i);
		end
	endtask
endmodule // cpsw_ser_host

// ===== verif/cpsw_ctrl_chk.sv
`timescale 1ns/1ns
// Port checker of the switch controller
module cpsw_ctrl_chk (
	// Clocking
	input wire clk_i,
	input wire rst_n_i,
	// Pins
	input wire ser_latch_i,
	input wire reset_pin_n_i,
	input wire shutdown_pin_n_i,
	input wire [3:0] oc_sense_i,
	input wire temp_hot_i,
	input wire temp_cool_i,
	// Outputs
	input wire [31:0] reg_rdata_o,
	input wire [2:0] slot_a_main_sw_o,
	input wire [3:0] slot_a_prog_sw_o,
	input wire [2:0] slot_b_main_sw_o,
	input wire [3:0] slot_b_prog_sw_o,
	input wire [3:0] current_limit_o,
	input wire overcurrent_flag_n_o,
	input wire irq_o
);
	wire [13:0] sw = {slot_a_main_sw_o, slot_a_prog_sw_o, slot_b_main_sw_o, slot_b_prog_sw_o};
	wire grounded = (sw == {3'h4, 4'h8, 3'h4, 4'h8}); // All four discharge switches closed
	wire [8:0] pins = {ser_latch_i, reset_pin_n_i, shutdown_pin_n_i, oc_sense_i, temp_hot_i,
		temp_cool_i};
	reg [8:0] pins_r; // Pins one cycle ago
	reg [3:0] quiet_r; // Cycles with no pin change
	// Count cycles since any pin that can move the switches changed
	always @(posedge clk_i) begin
		pins_r <= pins;
		if (!rst_n_i || pins_r != pins) begin
			quiet_r <= 4'h0;
		end else if (quiet_r != 4'hf) begin
			quiet_r <= quiet_r + 4'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence pin_reset_held; (!reset_pin_n_i)[*6]; endsequence
	sequence fault_held; (|oc_sense_i || temp_hot_i)[*6]; endsequence
	sequence sense_quiet; (oc_sense_i == 4'h0)[*6]; endsequence
	sequence all_clear; (oc_sense_i == 4'h0 && !temp_hot_i && temp_cool_i)[*6]; endsequence
	a_reset_grounds: assert property (disable iff (1'b0) !rst_n_i |=> grounded
		&& overcurrent_flag_n_o && !irq_o && current_limit_o == 4'h0 && reg_rdata_o == 32'h0)
		else $error("outputs not at reset state");
	a_pin_grounds: assert property (pin_reset_held |-> grounded)
		else $error("reset pin did not ground outputs");
	a_flag_low: assert property (fault_held |-> !overcurrent_flag_n_o)
		else $error("flag high during fault");
	a_flag_quiet: assert property (all_clear |-> overcurrent_flag_n_o)
		else $error("flag low without fault");
	a_limit_idle: assert property (sense_quiet |-> current_limit_o == 4'h0)
		else $error("limiting without overcurrent");
	a_word_held: assert property (quiet_r >= 4'ha |-> $stable(sw))
		else $error("switches moved without latch");
	a_main_onehot: assert property ($onehot0(slot_a_main_sw_o) && $onehot0(slot_b_main_sw_o))
		else $error("main supply switches overlap");
	a_prog_onehot: assert property ($onehot0(slot_a_prog_sw_o) && $onehot0(slot_b_prog_sw_o))
		else $error("program supply switches overlap");
endmodule // cpsw_ctrl_chk

// ===== verif/tb.sv
`timescale 1ns/1ns
`include "cpsw_regs.vh"
// Bench of the card power switch controller
module tb;
	localparam [13:0] GND = {3'h4, 4'h8, 3'h4, 4'h8}; // All outputs grounded
	reg clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg ce_i = 1'b1;
	reg reset_pin_n_i = 1'b1;
	reg shutdown_pin_n_i = 1'b1;
	reg [3:0] oc_sense_i = 4'h0;
	reg temp_hot_i = 1'b0;
	reg temp_cool_i = 1'b1;
	reg [3:0] reg_addr_i = 4'h0;
	reg [31:0] reg_wdata_i = 32'h0;
	reg reg_wr_i = 1'b0;
	reg reg_rd_i = 1'b0;
	wire ser_data_i, ser_clock_i, ser_latch_i, overcurrent_flag_n_o, irq_o;
	wire [31:0] reg_rdata_o;
	wire [2:0] slot_a_main_sw_o, slot_b_main_sw_o;
	wire [3:0] slot_a_prog_sw_o, slot_b_prog_sw_o, current_limit_o;
	wire [13:0] sw = {slot_a_main_sw_o, slot_a_prog_sw_o, slot_b_main_sw_o, slot_b_prog_sw_o};
	integer n_errors = 0;
	integer tests_run = 0;
	integer i;
	reg [10:0] w; // Last word latched
	always #2 clk_i = ~clk_i;
	cpsw_ctrl i_cpsw_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .ser_data_i(ser_data_i),
		.ser_clock_i(ser_clock_i), .ser_latch_i(ser_latch_i), .reset_pin_n_i(reset_pin_n_i),
		.shutdown_pin_n_i(shutdown_pin_n_i), .oc_sense_i(oc_sense_i), .temp_hot_i(temp_hot_i),
		.temp_cool_i(temp_cool_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.slot_a_main_sw_o(slot_a_main_sw_o), .slot_a_prog_sw_o(slot_a_prog_sw_o),
		.slot_b_main_sw_o(slot_b_main_sw_o), .slot_b_prog_sw_o(slot_b_prog_sw_o),
		.current_limit_o(current_limit_o), .overcurrent_flag_n_o(overcurrent_flag_n_o),
		.irq_o(irq_o));
	cpsw_ser_host i_cpsw_ser_host (.clk_i(clk_i), .ser_data_o(ser_data_i),
		.ser_clock_o(ser_clock_i), .ser_latch_o(ser_latch_i));
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("Error %s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	function [2:0] main_sel(input [1:0] c);
		main_sel = (c == 2'h1) ? 3'h1 : (c == 2'h2) ? 3'h2 : 3'h4;
	endfunction
	function [3:0] prog_sel(input [1:0] c, input lvl);
		prog_sel = (c == 2'h0) ? 4'h8 : (c == 2'h1) ? (lvl ? 4'h2 : 4'h1) : (c == 2'h2) ? 4'h4 : 4'h0;
	endfunction
	// Expected closures of a latched word
	function [13:0] exp_sw(input [10:0] x);
		exp_sw = x[8] ? {main_sel({x[3], x[2]}), prog_sel({x[0], x[1]}, x[9]),
			main_sel({x[6], x[7]}), prog_sel({x[4], x[5]}, x[10])} : 14'h0;
	endfunction
	function [10:0] mk(input integer am, ap, al, bm, bp, bl, run);
		mk = {bl[0], al[0], run[0], bm[0], bm[1], bp[0], bp[1], am[1], am[0], ap[0], ap[1]};
	endfunction
	task load(input [10:0] x);
		begin
			i_cpsw_ser_host.send({5'h0, x}, 11, 1'b1);
			w = x;
			repeat (8) @(posedge clk_i);
		end
	endtask
	task settle;
		repeat (8) @(posedge clk_i);
	endtask
	task reg_rd(input [3:0] a, input [31:0] e);
		begin
			reg_addr_i <= a;
			reg_rd_i <= 1'b1;
			@(posedge clk_i);
			reg_rd_i <= 1'b0;
			#1 chk("rdata", reg_rdata_o, e);
			@(posedge clk_i);
		end
	endtask
	task t_reset;
		begin
			chk("sw", sw, GND);
			chk("flag", overcurrent_flag_n_o, 1);
			$display("t_reset done");
		end
	endtask
	task t_decode;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				load(mk(0, 0, 0, 0, 0, 0, 1)); // Drop to 0 V before a new level
				load(mk(i % 4, i % 4, i / 4, 3 - i % 4, 3 - i % 4, 1 - i / 4, 1));
				chk("sw", sw, exp_sw(w));
			end
			$display("t_decode done");
		end
	endtask
	task t_shutdown;
		begin
			load(mk(1, 1, 0, 2, 2, 0, 0));
			chk("sw", sw, 14'h0);
			reg_rd(`CPSW_ADDR_WORD, {14'h0, 2'h3, 5'h0, w});
			load(mk(1, 1, 0, 2, 2, 0, 1));
			shutdown_pin_n_i <= 1'b0;
			settle;
			chk("sw", sw, 14'h0);
			shutdown_pin_n_i <= 1'b1;
			settle;
			chk("sw", sw, exp_sw(w));
			i_cpsw_ser_host.send({5'h0, mk(2, 3, 0, 1, 1, 1, 1)}, 11, 1'b0);
			settle;
			chk("sw", sw, exp_sw(w));
			w = mk(2, 3, 0, 1, 1, 1, 1);
			i_cpsw_ser_host.send({3'h0, w, 2'h3}, 13, 1'b1);
			settle;
			chk("sw", sw, exp_sw(w));
			$display("t_shutdown done");
		end
	endtask
	task t_pin_reset;
		begin
			reset_pin_n_i <= 1'b0;
			settle;
			chk("sw", sw, GND);
			load(mk(1, 1, 1, 1, 1, 1, 1));
			chk("sw", sw, GND);
			reset_pin_n_i <= 1'b1;
			settle;
			chk("sw", sw, GND);
			load(mk(1, 0, 0, 2, 0, 0, 1));
			chk("sw", sw, exp_sw(w));
			$display("t_pin_reset done");
		end
	endtask
	task t_prot;
		begin
			oc_sense_i <= 4'h1;
			settle;
			chk("limit", current_limit_o, 4'h1);
			chk("sw", sw, exp_sw(w));
			chk("flag", overcurrent_flag_n_o, 0);
			oc_sense_i <= 4'h0;
			temp_hot_i <= 1'b1;
			temp_cool_i <= 1'b0;
			settle;
			chk("sw", sw, 14'h0);
			reg_rd(`CPSW_ADDR_WORD, {13'h0, 3'h5, 5'h0, w});
			chk("flag", overcurrent_flag_n_o, 0);
			temp_hot_i <= 1'b0;
			settle;
			chk("sw", sw, 14'h0);
			temp_cool_i <= 1'b1;
			settle;
			chk("sw", sw, exp_sw(w));
			chk("flag", overcurrent_flag_n_o, 1);
			$display("t_prot done");
		end
	endtask
	// Clock enable low must freeze the switches against pin changes
	task t_freeze;
		begin
			ce_i <= 1'b0;
			shutdown_pin_n_i <= 1'b0;
			settle;
			chk("sw", sw, exp_sw(w));
			shutdown_pin_n_i <= 1'b1;
			settle;
			ce_i <= 1'b1;
			settle;
			chk("sw", sw, exp_sw(w));
			$display("t_freeze done");
		end
	endtask
	task t_regs;
		begin
			reg_rd(`CPSW_ADDR_STATUS, 32'h23);
			reg_rd(`CPSW_ADDR_STATUS, 32'h0);
			reg_addr_i <= `CPSW_ADDR_MASK;
			reg_wdata_i <= 32'h1;
			reg_wr_i <= 1'b1;
			@(posedge clk_i);
			reg_wr_i <= 1'b0;
			reg_rd(`CPSW_ADDR_MASK, 32'h1);
			chk("irq", irq_o, 0);
			load(mk(2, 2, 0, 1, 2, 0, 1));
			chk("irq", irq_o, 1);
			reg_rd(`CPSW_ADDR_STATUS, 32'h1);
			@(posedge clk_i);
			chk("irq", irq_o, 0);
			reg_rd(`CPSW_ADDR_WORD, {16'h1, 5'h0, w});
			reg_rd(4'hc, 32'h0);
			$display("t_regs done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("Checks %0d mismatches %0d", tests_run, n_errors);
			if (n_errors == 0 && tests_run > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		t_reset;
		t_decode;
		t_shutdown;
		t_pin_reset;
		t_prot;
		t_freeze;
		t_regs;
		tally_and_finish;
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		n_errors = n_errors + 1;
		tally_and_finish;
	end
endmodule // tb
bind cpsw_ctrl cpsw_ctrl_chk i_cpsw_ctrl_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.ser_latch_i(ser_latch_i), .reset_pin_n_i(reset_pin_n_i), .shutdown_pin_n_i(shutdown_pin_n_i),
	.oc_sense_i(oc_sense_i), .temp_hot_i(temp_hot_i), .temp_cool_i(temp_cool_i),
	.reg_rdata_o(reg_rdata_o), .slot_a_main_sw_o(slot_a_main_sw_o),
	.slot_a_prog_sw_o(slot_a_prog_sw_o), .slot_b_main_sw_o(slot_b_main_sw_o),
	.slot_b_prog_sw_o(slot_b_prog_sw_o), .current_limit_o(current_limit_o),
	.overcurrent_flag_n_o(overcurrent_flag_n_o), .irq_o(irq_o));
